// ---- logic/sdfm_pkg.sv ----
// Constants, field positions and carrier types of the serial diagnostic fault manager.
// Assumes one 25 MHz system clock shared by every module of the block.
`default_nettype none

package sdfm_pkg;

  // ******************************************************************
  // Timing.
  // ******************************************************************
  localparam int unsigned SDFM_CLK_HZ          = 25000000;
  localparam int unsigned SDFM_WARN_TIME_MIN   = 30;
  localparam int unsigned SDFM_COMM_TIMEOUT_MS = 100;
  localparam logic [39:0] SDFM_WARN_CYCLES =
    40'(64'(SDFM_WARN_TIME_MIN) * 64'h3C * 64'(SDFM_CLK_HZ));
  localparam logic [31:0] SDFM_COMM_CYCLES =
    32'(64'(SDFM_COMM_TIMEOUT_MS) * 64'(SDFM_CLK_HZ) / 64'h3E8);

  // ******************************************************************
  // Chain frame and byte fields.
  // ******************************************************************
  localparam int unsigned SDFM_MAX_DEVICES = 31;
  localparam int unsigned SDFM_SLOT_BITS   = 16;
  localparam int unsigned SDFM_REQ_MAGNET  = 0;
  localparam int unsigned SDFM_REQ_RESET   = 7;
  localparam logic [7:0]  SDFM_BYTE_ZERO   = 8'h00;
  localparam logic [15:0] SDFM_SLOT_ZERO   = 16'h0000;

  // ******************************************************************
  // Types.
  // ******************************************************************
  typedef enum logic [2:0] {
    SDFM_ST_RUN  = 3'b001,
    SDFM_ST_ERR  = 3'b010,
    SDFM_ST_LOCK = 3'b100
  } sdfm_state_t;

  typedef struct packed {
    logic ext_volt_a;
    logic ext_volt_b;
    logic cross_short;
    logic over_temp;
    logic out_fault_a;
    logic out_fault_b;
    logic out_short;
    logic actuator_fault;
    logic internal_err;
    logic under_volt;
  } sdfm_diag_t;

  typedef struct packed {
    logic door_closed;
    logic actuator_detected;
    logic actuator_locked;
    logic safety_input_a;
    logic safety_input_b;
  } sdfm_sense_t;

endpackage

`default_nettype wire

// ---- logic/sdfm_warn_timer.sv ----
// Warning persistence timer of the serial diagnostic fault manager.
// Assumes an asynchronous active-low reset already released in step with the clock.
`default_nettype none

module sdfm_warn_timer
  import sdfm_pkg::*;
#(
  parameter logic [39:0] LIMIT = SDFM_WARN_CYCLES
) (
  // Clock and reset.
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // Warning level and expiry.
  input  wire logic warn_i,
  output logic      expired_o
);

  logic [39:0] cnt_q;
  logic [39:0] cnt_d;

  // ******************************************************************
  // Counts while the warning stands and restarts when it drops.
  // ******************************************************************
  always_comb begin
    cnt_d = cnt_q;
    if (!warn_i) begin
      cnt_d = '0;
    end else if (cnt_q != LIMIT) begin
      cnt_d = cnt_q + 40'h0000000001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign expired_o = warn_i && (cnt_q == LIMIT);

endmodule

`default_nettype wire

// ---- logic/sdfm_serial_link.sv ----
// Chain slot shifter of the serial diagnostic fault manager.
// Assumes the gateway frames each transfer with a level and shifts one bit per clock.
`default_nettype none

module sdfm_serial_link
  import sdfm_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Serial diagnostic line.
  input  wire logic        frame_i,
  input  wire logic        sd_in_i,
  output logic             sd_out_o,
  // Slot contents.
  input  wire logic [15:0] load_word_i,
  output logic [7:0]       req_o,
  output logic             req_valid_o,
  output logic             frame_err_o
);

  logic [15:0] sh_q,    sh_d;
  logic [3:0]  cnt_q,   cnt_d;
  logic        frame_q;
  logic [7:0]  req_q,   req_d;
  logic        val_q,   val_d;
  logic        ferr_q,  ferr_d;

  // ******************************************************************
  // Shifts the slot during a frame and swaps it at the frame end.
  // ******************************************************************
  always_comb begin
    sh_d   = sh_q;
    cnt_d  = cnt_q;
    req_d  = req_q;
    val_d  = 1'b0;
    ferr_d = 1'b0;
    if (frame_i) begin
      sh_d  = {sh_q[14:0], sd_in_i};
      cnt_d = cnt_q + 4'h1;
    end else if (frame_q) begin
      cnt_d = 4'h0;
      sh_d  = load_word_i;
      if (cnt_q == 4'h0) begin
        req_d = sh_q[15:8];
        val_d = 1'b1;
      end else begin
        ferr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_q    <= SDFM_SLOT_ZERO;
      cnt_q   <= 4'h0;
      frame_q <= 1'b0;
      req_q   <= SDFM_BYTE_ZERO;
      val_q   <= 1'b0;
      ferr_q  <= 1'b0;
    end else begin
      sh_q    <= sh_d;
      cnt_q   <= cnt_d;
      frame_q <= frame_i;
      req_q   <= req_d;
      val_q   <= val_d;
      ferr_q  <= ferr_d;
    end
  end

  assign sd_out_o    = sh_q[15];
  assign req_o       = req_q;
  assign req_valid_o = val_q;
  assign frame_err_o = ferr_q;

endmodule

`default_nettype wire

// ---- logic/sdfm_top.sv ----
// Serial diagnostic and fault manager of a guard door solenoid interlock.
// Assumes sensing inputs are synchronous to clk_sys_i and the gateway frames the chain.
//
// Function
// - Chain carries up to 31 devices.
// - Diagnostic traffic passes serial input to output.
// - Each slot returns state without any poll.
// - Lost communication keeps present switching state.
// - Internal error disables both safety outputs.
// - Error clears on ack falling or door open.
// - Output faults hold until the next release.
// - Double output fault or short locks out.
// - Only power cycle clears the lockout.
// - Minor faults warn while outputs stay on.
// - Warning clears by itself when cause leaves.
// - Warning lasting 30 minutes switches outputs off.
// - Request bit 0 energises the magnet.
// - Response byte carries state, warning, error.
// - Detail byte follows a warning or error.
// - Warning detail byte field layout.
// - Error detail byte field layout.
`default_nettype none

module sdfm_top
  import sdfm_pkg::*;
#(
  parameter logic [39:0] WARN_CYCLES = SDFM_WARN_CYCLES,
  parameter logic [31:0] COMM_CYCLES = SDFM_COMM_CYCLES
) (
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Serial diagnostic line.
  input  wire logic        serial_diag_line_frame_i,
  input  wire logic        serial_diag_line_i,
  output logic             serial_diag_line_o,
  // Sensing and fault detection.
  input  wire sdfm_sense_t sense_i,
  input  wire sdfm_diag_t  diag_i,
  // Actuation and indication.
  output logic             safety_output_a_o,
  output logic             safety_output_b_o,
  output logic             magnet_o,
  output logic             red_flash_o,
  output logic             lockout_o
);

  // ******************************************************************
  // Reset release.
  // ******************************************************************
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // ******************************************************************
  // Chain slot.
  // ******************************************************************
  logic [7:0]  req;
  logic        req_valid;
  logic        frame_err;
  logic [15:0] load_word;

  // Each device inserts one slot into the ring.
  sdfm_serial_link u_link (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n),
    .frame_i     (serial_diag_line_frame_i),
    .sd_in_i     (serial_diag_line_i),
    .sd_out_o    (serial_diag_line_o),
    .load_word_i (load_word),
    .req_o       (req),
    .req_valid_o (req_valid),
    .frame_err_o (frame_err)
  );

  // ******************************************************************
  // Warning collection and timer.
  // ******************************************************************
  logic       comm_err_q, comm_err_d;
  logic [31:0] comm_cnt_q, comm_cnt_d;
  logic [7:0] warn_byte;
  logic       warn;
  logic       warn_expired;

  always_comb begin
    comm_cnt_d = comm_cnt_q;
    comm_err_d = comm_err_q;
    if (req_valid) begin
      comm_cnt_d = 32'h00000000;
      comm_err_d = 1'b0;
    end else if (frame_err || comm_cnt_q == COMM_CYCLES) begin
      comm_err_d = 1'b1;
    end else begin
      comm_cnt_d = comm_cnt_q + 32'h00000001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      comm_cnt_q <= 32'h00000000;
      comm_err_q <= 1'b0;
    end else begin
      comm_cnt_q <= comm_cnt_d;
      comm_err_q <= comm_err_d;
    end
  end

  // Warning bits follow their causes directly.
  assign warn_byte = {diag_i.under_volt, comm_err_q, diag_i.internal_err, 1'b0,
                      diag_i.over_temp, diag_i.cross_short,
                      diag_i.ext_volt_b, diag_i.ext_volt_a};
  assign warn = |warn_byte;

  sdfm_warn_timer #(
    .LIMIT (WARN_CYCLES)
  ) u_warn_timer (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .warn_i    (warn),
    .expired_o (warn_expired)
  );

  // ******************************************************************
  // Fault classification.
  // ******************************************************************
  sdfm_state_t state_q, state_d;
  logic fault_a_q, fault_a_d;
  logic fault_b_q, fault_b_d;
  logic expired_q, expired_d;
  logic ack_q, ack_d;
  logic door_q;
  logic ack_fall;
  logic door_opened;
  logic err_cause;

  assign ack_fall    = req_valid && ack_q && !req[SDFM_REQ_RESET];
  assign door_opened = door_q && !sense_i.door_closed;

  always_comb begin
    ack_d = ack_q;
    if (req_valid) begin
      ack_d = req[SDFM_REQ_RESET];
    end
    // Output faults hold until the next release; a new fault wins.
    fault_a_d = diag_i.out_fault_a || (fault_a_q && !door_opened);
    fault_b_d = diag_i.out_fault_b || (fault_b_q && !door_opened);
    expired_d = warn_expired || (expired_q && warn);
    err_cause = diag_i.internal_err || diag_i.actuator_fault || fault_a_d || fault_b_d ||
                expired_d;
    state_d = state_q;
    case (state_q)
      SDFM_ST_RUN: begin
        if (err_cause) begin
          state_d = SDFM_ST_ERR;
        end
      end
      SDFM_ST_ERR: begin
        if (!err_cause && (ack_fall || door_opened)) begin
          state_d = SDFM_ST_RUN;
        end
      end
      SDFM_ST_LOCK: begin
        state_d = SDFM_ST_LOCK;
      end
      default: begin
        state_d = SDFM_ST_ERR;
      end
    endcase
    if ((fault_a_q && fault_b_q) || diag_i.out_short) begin
      state_d = SDFM_ST_LOCK;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= SDFM_ST_RUN;
      fault_a_q <= 1'b0;
      fault_b_q <= 1'b0;
      expired_q <= 1'b0;
      ack_q     <= 1'b0;
      door_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      fault_a_q <= fault_a_d;
      fault_b_q <= fault_b_d;
      expired_q <= expired_d;
      ack_q     <= ack_d;
      door_q    <= sense_i.door_closed;
    end
  end

  // ******************************************************************
  // Outputs and response slot.
  // ******************************************************************
  logic out_en_d, out_en_q;
  logic magnet_d, magnet_q;
  logic flash_d, flash_q;
  logic lock_d, lock_q;
  logic is_err;
  logic [7:0] rsp_byte;
  logic [7:0] err_byte;

  assign is_err = (state_q != SDFM_ST_RUN);

  always_comb begin
    out_en_d = (state_d == SDFM_ST_RUN) && !diag_i.internal_err && sense_i.door_closed &&
               sense_i.actuator_locked && sense_i.safety_input_a && sense_i.safety_input_b;
    // Magnet only moves on a good request; otherwise it holds.
    magnet_d = magnet_q;
    if (req_valid) begin
      magnet_d = req[SDFM_REQ_MAGNET];
    end
    flash_d = warn || (state_d != SDFM_ST_RUN);
    lock_d   = (state_d == SDFM_ST_LOCK);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      out_en_q <= 1'b0;
      magnet_q <= 1'b0;
      flash_q  <= 1'b0;
      lock_q   <= 1'b0;
    end else begin
      out_en_q <= out_en_d;
      magnet_q <= magnet_d;
      flash_q  <= flash_d;
      lock_q   <= lock_d;
    end
  end

  // Response and detail bytes of this device's slot.
  assign rsp_byte = {is_err, warn, sense_i.door_closed,
                     sense_i.safety_input_a && sense_i.safety_input_b, 1'b0,
                     sense_i.actuator_detected && sense_i.actuator_locked,
                     sense_i.actuator_detected, out_en_q};
  assign err_byte = {2'b00, diag_i.internal_err, diag_i.actuator_fault,
                     expired_q && diag_i.over_temp, diag_i.out_short,
                     fault_b_q, fault_a_q};
  assign load_word = {rsp_byte, is_err ? err_byte : warn_byte};

  assign safety_output_a_o = out_en_q;
  assign safety_output_b_o = out_en_q;
  assign magnet_o          = magnet_q;
  assign red_flash_o       = flash_q;
  assign lockout_o         = lock_q;

  // ******************************************************************
  // Assertions.
  // ******************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  sequence s_ack;
    req_valid && ack_q && !req[SDFM_REQ_RESET];
  endsequence

  sequence s_held_err;
    state_q == SDFM_ST_ERR && sense_i.door_closed && door_q && !ack_fall;
  endsequence

  property p_internal_off;
    diag_i.internal_err |=> !safety_output_a_o && !safety_output_b_o;
  endproperty
  a_internal_off: assert property (p_internal_off) else $error("outputs on in error");

  property p_err_hold;
    s_held_err |=> state_q != SDFM_ST_RUN;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error cleared without ack");

  property p_ack_clear;
    s_ack ##0 (state_q == SDFM_ST_ERR && !err_cause && state_d != SDFM_ST_LOCK) |=> !is_err;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("error kept after ack");

  property p_fault_hold;
    fault_a_q && sense_i.door_closed |=> fault_a_q;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("output fault lost early");

  property p_lock_enter;
    fault_a_q && fault_b_q |=> lockout_o;
  endproperty
  a_lock_enter: assert property (p_lock_enter) else $error("no lockout on double fault");

  property p_lock_stay;
    lockout_o |=> lockout_o && !safety_output_a_o;
  endproperty
  a_lock_stay: assert property (p_lock_stay) else $error("lockout released");

  property p_warn_expire;
    warn_expired |-> ##[1:2] (!safety_output_a_o && red_flash_o);
  endproperty
  a_warn_expire: assert property (p_warn_expire) else $error("warning expiry ignored");

  property p_magnet_hold;
    !req_valid |=> $stable(magnet_o);
  endproperty
  a_magnet_hold: assert property (p_magnet_hold) else $error("magnet moved without request");

  property p_magnet_follow;
    req_valid |=> magnet_o == $past(req[SDFM_REQ_MAGNET]);
  endproperty
  a_magnet_follow: assert property (p_magnet_follow) else $error("magnet ignores bit 0");

  property p_warn_flag;
    warn |-> load_word[14];
  endproperty
  a_warn_flag: assert property (p_warn_flag) else $error("warning flag missing");

endmodule

`default_nettype wire

// ---- test/sdfm_gateway.sv ----
// Gateway model that shifts frames of request slots through the chain.
// Assumes the bench calls xfer only between frames, one call at a time.
`default_nettype none

module sdfm_gateway (
  // Clock.
  input  wire logic clk_sys_i,
  // Chain line.
  input  wire logic sd_i,
  output logic      frame_o,
  output logic      sd_o
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [15:0] PASS = 16'hC3A5;

  logic bit_q = 1'b0;
  logic alt_q = 1'b0;

  initial frame_o = 1'b0;

  // Released line toggles every cycle outside frames.
  always @(posedge clk_sys_i) begin
    alt_q <= ~alt_q;
  end
  assign sd_o = frame_o ? bit_q : alt_q;

  // Own slot goes last, other slots carry a fixed pattern.
  task automatic xfer(input logic [7:0] req, input int nbits,
                      output logic [15:0] head, output logic [15:0] tail);
    int          j;
    logic [15:0] own;
    logic [15:0] rx;
    own = {req, 8'h5A};
    rx = 16'h0000;
    head = 16'h0000;
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk_sys_i);
      #1;
      j = nbits - 1 - i;
      frame_o = 1'b1;
      bit_q = (j < 16) ? own[j] : PASS[j % 16];
      rx = {rx[14:0], sd_i};
      if (i == 15) begin
        head = rx;
      end
    end
    @(posedge clk_sys_i);
    #1;
    frame_o = 1'b0;
    tail = rx;
  endtask

endmodule

`default_nettype wire

// ---- test/serial_diag_fault_manager_test.sv ----
// Self-checking bench of the serial diagnostic fault manager.
// Assumes sdfm_gateway is the only other party on the chain.
`default_nettype none

module serial_diag_fault_manager_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sdfm_pkg::*;

  localparam logic [15:0] BASE = 16'h3700;

  logic        clk_sys_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        frame;
  logic        sdi;
  logic        sdo;
  sdfm_sense_t sense_i   = '1;
  sdfm_diag_t  diag_i    = '0;
  logic        out_a;
  logic        out_b;
  logic        magnet;
  logic        flash;
  logic        lock;
  logic [15:0] q_e[$];
  logic [15:0] q_m[$];
  logic [15:0] head;
  logic [15:0] tail;
  logic [15:0] lfsr      = 16'h0033;
  int          dpos[5]   = '{9, 8, 7, 6, 0};
  int          wpos[5]   = '{0, 1, 2, 3, 7};
  int          failures  = 0;
  int          tests_run = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  sdfm_top #(.WARN_CYCLES(40'h28), .COMM_CYCLES(32'h3E8)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .serial_diag_line_frame_i(frame), .serial_diag_line_i(sdi),
    .serial_diag_line_o(sdo), .sense_i(sense_i), .diag_i(diag_i),
    .safety_output_a_o(out_a), .safety_output_b_o(out_b),
    .magnet_o(magnet), .red_flash_o(flash), .lockout_o(lock));

  sdfm_gateway i_gw (.clk_sys_i(clk_sys_i), .sd_i(sdo), .frame_o(frame), .sd_o(sdi));

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic summarize();
    $display("Checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic outs(input logic [4:0] e, input logic [4:0] m);
    chk("outputs", {11'h000, e & m}, {11'h000, {out_a, out_b, magnet, flash, lock} & m});
  endtask

  task automatic rst();
    rst_n_i = 1'b0;
    tick(6);
    outs(5'b00000, 5'b11111);
    chk("serial out", 16'h0000, {15'h0000, sdo});
    rst_n_i = 1'b1;
    tick(4);
    q_e.delete();
    q_m.delete();
  endtask

  // Sends a frame of n slots; queues what the device loads at its end.
  task automatic frame_tx(input logic [7:0] r, input int n, input logic [15:0] e,
                          input logic [15:0] m);
    logic [15:0] pe;
    logic [15:0] pm;
    i_gw.xfer(r, 16 * n, head, tail);
    if (q_e.size() > 0) begin
      pe = q_e.pop_front();
      pm = q_m.pop_front();
      chk("response", pe & pm, head & pm);
    end
    if (n > 1) begin
      chk("passed slot", 16'hC3A5, tail);
    end
    q_e.push_back(e);
    q_m.push_back(m);
    tick(4);
  endtask

  task automatic door();
    sense_i.door_closed = 1'b0;
    tick(3);
    sense_i.door_closed = 1'b1;
    tick(2);
  endtask

  initial begin
    repeat (90000) @(posedge clk_sys_i);
    failures++;
    summarize();
  end

  initial begin
    rst();
    frame_tx(8'h01, 1, BASE, 16'hFFFF);
    outs(5'b11100, 5'b11111);
    frame_tx(8'h7E, 1, BASE, 16'hFFFF);
    outs(5'b11000, 5'b11111);
    frame_tx(8'h01, 31, BASE, 16'hFFFF);
    outs(5'b11100, 5'b11111);
    i_gw.xfer(8'h00, 15, head, tail);
    q_e.delete();
    q_m.delete();
    tick(4);
    outs(5'b11100, 5'b11100);
    frame_tx(8'h01, 1, BASE, 16'hBFBF);
    for (int k = 0; k < 5; k++) begin
      diag_i = sdfm_diag_t'(10'h001 << dpos[k]);
      frame_tx(8'h01, 1, 16'h4000 | BASE | (16'h0001 << wpos[k]), 16'hFFFF);
      if (k == 3) begin
        outs(5'b11100, 5'b11100);
      end
      diag_i = '0;
      frame_tx(8'h01, 1, BASE, 16'hFFFF);
    end
    diag_i.over_temp = 1'b1;
    tick(50);
    outs(5'b00110, 5'b11111);
    frame_tx(8'h81, 1, 16'hF608, 16'hFFFF);
    diag_i = '0;
    frame_tx(8'h81, 1, 16'hB600, 16'hFFFF);
    frame_tx(8'h01, 1, 16'hB600, 16'hFFFF);
    frame_tx(8'h01, 1, BASE, 16'hFFFF);
    diag_i.internal_err = 1'b1;
    tick(2);
    outs(5'b00110, 5'b11111);
    frame_tx(8'h81, 1, 16'hB620, 16'hBFFF);
    diag_i = '0;
    frame_tx(8'h01, 1, 16'hB600, 16'hFFFF);
    frame_tx(8'h01, 1, BASE, 16'hFFFF);
    outs(5'b11100, 5'b11111);
    diag_i.actuator_fault = 1'b1;
    tick(2);
    frame_tx(8'h01, 1, 16'hB610, 16'hBFFF);
    diag_i = '0;
    frame_tx(8'h01, 1, 16'hB600, 16'hBFFF);
    door();
    frame_tx(8'h01, 1, BASE, 16'hFFFF);
    frame_tx(8'h01, 1, BASE, 16'hFFFF);
    diag_i.out_fault_a = 1'b1;
    tick(2);
    diag_i = '0;
    frame_tx(8'h81, 1, 16'hB601, 16'hBFFF);
    frame_tx(8'h01, 1, 16'hB601, 16'hBFFF);
    door();
    frame_tx(8'h81, 1, BASE, 16'hFFFF);
    frame_tx(8'h01, 1, BASE, 16'hFFFF);
    frame_tx(8'h01, 1, BASE, 16'hFFFF);
    repeat (6) begin
      lfsr = nxt(lfsr);
      sense_i = sdfm_sense_t'(lfsr[4:0]);
      frame_tx(8'h01, 1, {2'b00, lfsr[4], lfsr[1] & lfsr[0], 1'b0, lfsr[3] & lfsr[2],
                          lfsr[3], 9'h000}, 16'h3600);
    end
    sense_i = '1;
    tick(2);
    for (int k = 0; k < 2; k++) begin
      diag_i = sdfm_diag_t'(k == 1 ? 10'h008 : 10'h030);
      tick(2);
      diag_i = '0;
      outs(5'b00011, 5'b11011);
      frame_tx(8'h81, 1, 16'h8000, 16'h8000);
      frame_tx(8'h01, 1, 16'h8000, 16'h8000);
      door();
      frame_tx(8'h01, 1, 16'h8000, 16'h8000);
      outs(5'b00011, 5'b11011);
      rst();
      chk("lockout", 16'h0000, {15'h0000, lock});
    end
    summarize();
  end

endmodule

`default_nettype wire
